// ### rtl/flash_command_sequencer.sv
// Command front end of a partitioned flash: decodes write sequences.
// Function
// - Protection setup: next write of lock data to the lock word, or any write to a user word, launches protection operation.
// - Status snapshot refreshes on every read strobe taken while ce_i is high.
// - Configuration setup without confirm sets sequence error.
// - Configuration loads from low sixteen address lines.
// - Configuration write returns partition to array reads.
// - Erase and lock confirm must hit same block.
// - Identifier/query reads use partition base plus offset.
// - Protection lock needs lock address and lock data.
// - User protection area is four words.
// - Reads between setup and confirm keep sequence.
// - Setup write puts partition into status mode.
// - Other partitions keep their array mode.
// - Wrong second write records a sequence error.
// - Error bits stay until reset or clear-status.
// - Reset leaves every partition in array mode.
// - Failed erase confirm: error, partition stays status.
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer
   import flash_cmd_pkg::*;
#(
   parameter int              ADDR_W   = 22,
   parameter int              PART_W   = 3,
   parameter int              BLOCK_AW = 15,
   parameter logic [15:0]     PROT_USER_BASE = 16'h0081
)(
   input  wire logic              clk_sys_i,
   input  wire logic              srst_i,
   input  wire logic              ce_i,
   input  wire logic              wr_stb_i,
   input  wire logic [ADDR_W-1:0] wr_addr_i,
   input  wire logic [15:0]       wr_data_i,
   input  wire logic              rd_stb_i,
   input  wire logic [ADDR_W-1:0] rd_addr_i,
   input  wire logic              wsm_busy_i,
   input  wire logic              prog_err_i,
   input  wire logic              erase_err_i,
   input  wire logic              vpp_err_i,
   input  wire logic              lock_err_i,
   input  wire logic              prog_susp_i,
   input  wire logic              erase_susp_i,
   output logic                   op_start_o,
   output var op_type             op_kind_o,
   output logic [ADDR_W-1:0]      op_addr_o,
   output logic [15:0]            op_data_o,
   output logic                   suspend_o,
   output logic                   resume_o,
   output logic [15:0]            config_o,
   output logic                   factory_program_mode_o,
   output logic [7:0]             status_o,
   output var mode_type           rd_mode_o,
   output logic [7:0]             rd_offset_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_FACTORY} state_type;

   // Partition index of an address.
   function automatic logic [PART_W-1:0] part_of(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1 -: PART_W];
   endfunction

   // Block index of an address.
   function automatic logic [ADDR_W-BLOCK_AW-1:0] block_of(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:BLOCK_AW];
   endfunction

   state_type         state;      // Sequencer state.
   logic [7:0]        pend_code;  // Setup code waiting for its confirm.
   logic [ADDR_W-1:0] pend_addr;  // Address of the setup cycle.
   logic [3:0]        err;        // Sticky bits 5, 4, 3 and 1.

   mode_table_if #(.PART_W(PART_W)) mt ();

   partition_mode_table #(.PART_W(PART_W)) u_table (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .mt        (mt)
   );

   // Write decode.
   wire       wr       = ce_i & wr_stb_i;
   wire [7:0] code     = wr_data_i[7:0];
   wire       idle     = (state == ST_IDLE);
   wire       waiting  = (state == ST_WAIT);
   wire       same_blk = (block_of(wr_addr_i) == block_of(pend_addr));
   wire       is_setup = (code == CMD_PROG_SETUP) | (code == CMD_PROG_ALT) |
                         (code == CMD_FACT_SETUP) | (code == CMD_ERASE_SETUP) |
                         (code == CMD_LOCK_SETUP) | (code == CMD_PROT_SETUP);
   wire       lock_code = (code == CMD_LOCK_BLOCK) | (code == CMD_CONFIRM) |
                          (code == CMD_LOCK_DOWN);
   wire [15:0] low_addr = wr_addr_i[15:0];
   wire       prot_lock_ok = (low_addr == PROT_LOCK_ADDR) &&
                             (wr_data_i == PROT_LOCK_DATA);
   wire       prot_user_ok = (low_addr >= PROT_USER_BASE) &&
                             (low_addr < PROT_USER_BASE + PROT_USER_WORDS);

   // Outcomes of the confirm write.
   wire good_prog  = (pend_code == CMD_PROG_SETUP) | (pend_code == CMD_PROG_ALT);
   wire good_prot  = (pend_code == CMD_PROT_SETUP) & (prot_lock_ok | prot_user_ok);
   wire good_erase = (pend_code == CMD_ERASE_SETUP) & (code == CMD_CONFIRM) & same_blk;
   wire good_fact  = (pend_code == CMD_FACT_SETUP) & (code == CMD_CONFIRM);
   wire good_cfg   = (pend_code == CMD_LOCK_SETUP) & (code == CMD_SET_CONFIG);
   wire good_lock  = (pend_code == CMD_LOCK_SETUP) & lock_code & same_blk;
   wire conf_ok    = good_prog | good_prot | good_erase | good_fact | good_cfg | good_lock;
   wire seq_err    = wr & waiting & ~conf_ok;
   wire clear_stat = wr & idle & (code == CMD_CLEAR_STAT);
   wire fact_stay  = (block_of(wr_addr_i) == block_of(pend_addr));

   // Operation kind chosen by the confirm write.
   op_type conf_kind;
   assign conf_kind = good_prog  ? OP_PROGRAM :
                      good_erase ? OP_ERASE :
                      good_fact  ? OP_FACTORY :
                      (good_prot & prot_lock_ok) ? OP_PROT_LOCK :
                      good_prot  ? OP_PROT_PROG :
                      (code == CMD_LOCK_BLOCK) ? OP_LOCK :
                      (code == CMD_CONFIRM) ? OP_UNLOCK : OP_LOCKDOWN;

   // Mode table writes: read commands and setups in idle, outcome in wait.
   wire idle_mode_cmd = (code == CMD_READ_ARRAY) | (code == CMD_READ_IDENT) |
                        (code == CMD_READ_QUERY) | (code == CMD_READ_STATUS) | is_setup;
   assign mt.set_en   = wr & ((idle & idle_mode_cmd) | waiting);
   assign mt.set_idx  = part_of(wr_addr_i);
   assign mt.set_mode = waiting ? (good_cfg ? MODE_ARRAY : MODE_STATUS) :
                        (code == CMD_READ_ARRAY) ? MODE_ARRAY :
                        (code == CMD_READ_IDENT) ? MODE_IDENT :
                        (code == CMD_READ_QUERY) ? MODE_QUERY : MODE_STATUS;
   assign mt.look_idx = part_of(rd_addr_i);

   // Sticky error bits: a set in the clearing cycle wins.
   wire [3:0] err_set  = {seq_err | erase_err_i, seq_err | prog_err_i, vpp_err_i, lock_err_i};
   wire [3:0] next_err = (clear_stat ? 4'h0 : err) | err_set;
   wire [7:0] srd = {~wsm_busy_i, erase_susp_i, err[3], err[2], err[1], prog_susp_i,
                     err[0], ~wsm_busy_i};

   // Sequencer state: setups wait, reads leave it alone, confirms resolve.
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         state     <= ST_IDLE;
         pend_code <= 8'h00;
         pend_addr <= '0;
      end
      else if (wr)
      begin
         unique case (state)
            ST_IDLE:
            begin
               if (is_setup)
               begin
                  state     <= ST_WAIT;
                  pend_code <= code;
                  pend_addr <= wr_addr_i;
               end
            end
            ST_WAIT:
            begin
               state <= (good_fact) ? ST_FACTORY : ST_IDLE;
            end
            ST_FACTORY:
            begin
               // A write outside the captured block ends factory mode.
               if (!fact_stay) state <= ST_IDLE;
            end
            // The unused state code falls back to idle.
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Launch strobes and captured address and data.
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         op_start_o <= 1'b0;
         op_kind_o  <= OP_PROGRAM;
         op_addr_o  <= '0;
         op_data_o  <= 16'h0000;
         suspend_o  <= 1'b0;
         resume_o   <= 1'b0;
      end
      else if (ce_i)
      begin
         op_start_o <= wr & ((waiting & conf_ok & ~good_cfg) |
                             ((state == ST_FACTORY) & fact_stay));
         op_kind_o  <= (state == ST_FACTORY) ? OP_FACTORY : conf_kind;
         if (wr)
         begin
            op_addr_o <= wr_addr_i;
            op_data_o <= wr_data_i;
         end
         suspend_o  <= wr & idle & (code == CMD_SUSPEND);
         resume_o   <= wr & idle & (code == CMD_CONFIRM);
      end
   end

   // Configuration, sticky errors, factory flag and read-side snapshot.
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         config_o               <= 16'h0000;
         err                    <= 4'h0;
         factory_program_mode_o <= 1'b0;
         status_o               <= 8'h00;
         rd_mode_o              <= MODE_ARRAY;
         rd_offset_o            <= 8'h00;
      end
      else if (ce_i)
      begin
         if (wr & waiting & good_cfg) config_o <= low_addr;
         err                    <= next_err;
         factory_program_mode_o <= (state == ST_FACTORY);
         if (rd_stb_i)
         begin
            status_o    <= srd;
            rd_mode_o   <= mt.look_mode;
            rd_offset_o <= rd_addr_i[7:0];
         end
      end
   end

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   chk_config_load: assert property (wr & waiting & good_cfg |=>
      config_o == $past(low_addr))
      else $error("Configuration not loaded from address.");
   chk_config_error: assert property (wr & waiting & (pend_code == CMD_LOCK_SETUP) &
      ~good_cfg & ~good_lock |=> err[3:2] == 2'b11)
      else $error("Missing configuration confirm not flagged.");
   chk_sticky_hold: assert property (ce_i & ~clear_stat & err[3] |=> err[3])
      else $error("Sticky error bit dropped without clear.");
   chk_setup_wait: assert property (wr & idle & is_setup |=>
      waiting && pend_code == $past(code))
      else $error("Setup write not held for confirm.");
   chk_read_keeps: assert property (waiting & ~(ce_i & wr_stb_i) |=> waiting)
      else $error("Read aborted a pending sequence.");
   chk_prot_launch: assert property (wr & waiting & good_prot |=> op_start_o &&
      op_kind_o inside {OP_PROT_PROG, OP_PROT_LOCK} && op_data_o == $past(wr_data_i))
      else $error("Protection operation not launched.");
   chk_erase_block: assert property (wr & waiting & (pend_code == CMD_ERASE_SETUP) &
      ~same_blk |=> ~op_start_o ##0 err[3])
      else $error("Erase confirm in other block launched.");
   chk_status_snap: assert property (ce_i & rd_stb_i |=> status_o[5:4] == $past(srd[5:4]))
      else $error("Status snapshot not refreshed.");
   chk_wrong_write: assert property (seq_err |=> (err[3:2] == 2'b11))
      else $error("Interrupting write not recorded.");
   chk_erase_status: assert property (wr & waiting & (pend_code == CMD_ERASE_SETUP) &
      ~good_erase |-> mt.set_en && mt.set_mode == MODE_STATUS)
      else $error("Failed erase left status mode.");

   cov_erase: cover property (wr & waiting & good_erase);
   cov_config: cover property (wr & waiting & good_cfg);
   cov_interleave: cover property (waiting & rd_stb_i ##1 wr & waiting & conf_ok);
   cov_seq_error: cover property (seq_err);
endmodule
`default_nettype wire

// ### rtl/flash_cmd_pkg.sv
// Package with command codes, mode and operation types and fixed addresses.
package flash_cmd_pkg;
   // First-cycle command codes.
   localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
   localparam logic [7:0] CMD_READ_IDENT  = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
   localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
   localparam logic [7:0] CMD_PROG_ALT    = 8'h10;
   localparam logic [7:0] CMD_FACT_SETUP  = 8'h30;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
   localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
   localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;
   localparam logic [7:0] CMD_PROT_SETUP  = 8'hC0;
   // Second-cycle codes after a lock or configuration setup.
   localparam logic [7:0] CMD_LOCK_BLOCK  = 8'h01;
   localparam logic [7:0] CMD_LOCK_DOWN   = 8'h2F;
   localparam logic [7:0] CMD_SET_CONFIG  = 8'h03;
   // Protection lock word address and the data word that locks it.
   localparam logic [15:0] PROT_LOCK_ADDR = 16'h0080;
   localparam logic [15:0] PROT_LOCK_DATA = 16'hFFFD;
   // Number of user protection words.
   localparam logic [15:0] PROT_USER_WORDS = 16'h0004;
   // Status bit positions.
   localparam int SR_DEV_READY = 7;
   localparam int SR_ERASE_SUS = 6;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR  = 4;
   localparam int SR_VPP_ERR   = 3;
   localparam int SR_PROG_SUS  = 2;
   localparam int SR_LOCK_ERR  = 1;
   localparam int SR_PART_RDY  = 0;
   // Read mode of one partition.
   typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_IDENT, MODE_QUERY} mode_type;
   // Operation handed to the write state machine.
   typedef enum logic [2:0] {OP_PROGRAM, OP_ERASE, OP_PROT_PROG, OP_PROT_LOCK,
                             OP_LOCK, OP_UNLOCK, OP_LOCKDOWN, OP_FACTORY} op_type;
endpackage

// ### rtl/mode_table_if.sv
// Interface between the command front end and the partition mode table.
`timescale 1ns/1ps
`default_nettype none
interface mode_table_if
   import flash_cmd_pkg::*;
#(
   parameter int PART_W = 3
);
   logic              set_en;   // Write one partition's mode.
   logic [PART_W-1:0] set_idx;  // Partition written.
   mode_type          set_mode; // Mode written.
   logic [PART_W-1:0] look_idx; // Partition looked up.
   mode_type          look_mode;// Mode of the looked-up partition.
   modport table_side (input set_en, set_idx, set_mode, look_idx, output look_mode);
   modport user_side  (output set_en, set_idx, set_mode, look_idx, input look_mode);
endinterface
`default_nettype wire

// ### rtl/partition_mode_table.sv
// Flip-flop table holding the read mode of every partition.
`timescale 1ns/1ps
`default_nettype none
module partition_mode_table
   import flash_cmd_pkg::*;
#(
   parameter int PART_W = 3
)(
   input  wire logic  clk_sys_i,
   input  wire logic  srst_i,
   input  wire logic  ce_i,
   mode_table_if.table_side mt
);
   localparam int NPART = 1 << PART_W;

   // One mode entry per partition.
   mode_type modes [NPART];

   // Lookup is a plain indexed read.
   assign mt.look_mode = modes[mt.look_idx];

   // Every partition starts in array mode after reset.
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         for (int i = 0; i < NPART; i++) modes[i] <= MODE_ARRAY;
      end
      else if (ce_i && mt.set_en)
      begin
         modes[mt.set_idx] <= mt.set_mode;
      end
   end

   // After reset the looked-up partition reads as array.
   chk_reset_array: assert property (@(posedge clk_sys_i)
      $fell(srst_i) |-> mt.look_mode == MODE_ARRAY)
      else $error("Partition not in array mode after reset.");
endmodule
`default_nettype wire

// ### bench/host_model.sv
// Host memory controller model issuing single write and read strobes.
`timescale 1ns/1ps
`default_nettype none
module host_model
#(
   parameter int ADDR_W = 22
)(
   input  wire logic         clk_sys_i,
   output logic              wr_stb_o,
   output logic [ADDR_W-1:0] wr_addr_o,
   output logic [15:0]       wr_data_o,
   output logic              rd_stb_o,
   output logic [ADDR_W-1:0] rd_addr_o
);
   // Idle bus at time zero.
   initial
   begin
      wr_stb_o  = 1'b0;
      wr_addr_o = '0;
      wr_data_o = 16'h0000;
      rd_stb_o  = 1'b0;
      rd_addr_o = '0;
   end
   // One write cycle; released lines are scrambled so no stale value lingers.
   task automatic wr(input logic [ADDR_W-1:0] ad, input logic [15:0] dt);
      @(negedge clk_sys_i);
      wr_stb_o  = 1'b1;
      wr_addr_o = ad;
      wr_data_o = dt;
      @(negedge clk_sys_i);
      wr_stb_o  = 1'b0;
      wr_addr_o = ~ad;
      wr_data_o = ~dt;
   endtask
   // One read cycle, the strobe standing for a chip or output enable toggle.
   task automatic rd(input logic [ADDR_W-1:0] ad);
      @(negedge clk_sys_i);
      rd_stb_o  = 1'b1;
      rd_addr_o = ad;
      @(negedge clk_sys_i);
      rd_stb_o  = 1'b0;
      rd_addr_o = ~ad;
   endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the flash command sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import flash_cmd_pkg::*;
();
   logic        clk_sys_i, srst_i, ce_i, wsm_busy_i, wr_stb_i, rd_stb_i;
   logic        prog_err_i, erase_err_i, vpp_err_i, lock_err_i, prog_susp_i, erase_susp_i;
   logic [21:0] wr_addr_i, rd_addr_i, op_addr_o, a, b, ad;
   logic [15:0] wr_data_i, op_data_o, config_o, d, v;
   logic        op_start_o, suspend_o, resume_o, factory_program_mode_o;
   logic [7:0]  status_o, rd_offset_o;
   op_type      op_kind_o;
   mode_type    rd_mode_o;
   logic [63:0] notes[$];        // Expected launch, suspend or resume events, oldest first.
   logic [63:0] w_seen, w_exp;   // Watcher's observed and expected event.
   int          bad_count, cmp_count, cycles, i, seed;
   op_type      lk [3] = '{OP_LOCK, OP_UNLOCK, OP_LOCKDOWN};
   logic [15:0] lc [3] = '{16'h0001, 16'h00D0, 16'h002F};
   logic [15:0] sc [3] = '{16'h0020, 16'h0060, 16'h00C0};
   logic [15:0] bc [3] = '{16'h00D0, 16'h0004, 16'h1234};

   flash_command_sequencer u_flash_command_sequencer (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
      .ce_i(ce_i), .wr_stb_i(wr_stb_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
      .rd_stb_i(rd_stb_i), .rd_addr_i(rd_addr_i), .wsm_busy_i(wsm_busy_i),
      .prog_err_i(prog_err_i), .erase_err_i(erase_err_i), .vpp_err_i(vpp_err_i),
      .lock_err_i(lock_err_i), .prog_susp_i(prog_susp_i), .erase_susp_i(erase_susp_i),
      .op_start_o(op_start_o), .op_kind_o(op_kind_o), .op_addr_o(op_addr_o),
      .op_data_o(op_data_o), .suspend_o(suspend_o), .resume_o(resume_o), .config_o(config_o),
      .factory_program_mode_o(factory_program_mode_o), .status_o(status_o),
      .rd_mode_o(rd_mode_o), .rd_offset_o(rd_offset_o));
   host_model u_host_model (.clk_sys_i(clk_sys_i), .wr_stb_o(wr_stb_i), .wr_addr_o(wr_addr_i),
      .wr_data_o(wr_data_i), .rd_stb_o(rd_stb_i), .rd_addr_o(rd_addr_i));

   // Free-running 100 MHz clock.
   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Compares one value and counts the outcome.
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         bad_count++;
      end
   endtask
   // Packs one expected event: pulse flags, kind, address and data.
   function automatic logic [63:0] ev(logic [2:0] f, op_type k, logic [21:0] ea, logic [15:0] ed);
      return {20'h0, f, k, ea, ed};
   endfunction
   // Reads one address, then checks the snapshot once it has settled.
   task automatic rd_chk(input logic [21:0] ra, input logic [7:0] st, input mode_type md);
      u_host_model.rd(ra);
      repeat (3) @(negedge clk_sys_i);
      chk(status_o, st);
      chk(rd_mode_o, md);
      chk(rd_offset_o, ra[7:0]);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Takes the oldest note whenever a pulse appears and compares it.
   // Outputs are looked at on the falling edge, where they have settled.
   always @(negedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         results();
      end
      else if (op_start_o === 1'b1 || suspend_o === 1'b1 || resume_o === 1'b1)
      begin
         w_seen = {20'h0, op_start_o, suspend_o, resume_o,
                   (op_start_o ? op_kind_o : OP_PROGRAM), op_addr_o, op_data_o};
         w_exp  = (notes.size() > 0) ? notes.pop_front() : 64'h0;
         chk(w_seen, w_exp);
      end
   end
   // Main sequence; inputs change on the falling edge.
   initial
   begin
      seed = $urandom(32'hC02CE865);
      {srst_i, ce_i, wsm_busy_i} = 3'b110;
      {prog_err_i, erase_err_i, vpp_err_i, lock_err_i, prog_susp_i, erase_susp_i} = 6'h00;
      repeat (10) @(negedge clk_sys_i);
      srst_i = 1'b0;
      rd_chk(22'h000000, 8'h81, MODE_ARRAY);
      chk(config_o, 16'h0000);
      // Erase with reads interleaved, confirmed elsewhere in the same block.
      a = {3'h2, 19'($urandom)};
      b = {a[21:15], 15'($urandom)};
      u_host_model.wr(a, 16'h0020);
      rd_chk(a, 8'h81, MODE_STATUS);
      rd_chk(a ^ 22'h080000, 8'h81, MODE_ARRAY);
      notes.push_back(ev(3'b100, OP_ERASE, b, 16'h00D0));
      u_host_model.wr(b, 16'h00D0);
      // Broken two-cycle sequences, second write in another block of the
      // same partition, raise sticky errors until cleared.
      for (i = 0; i < 3; i++)
      begin
         ad = (i == 2) ? 22'h000085 : a;
         u_host_model.wr(ad, sc[i]);
         u_host_model.wr(ad ^ 22'h008000, bc[i]);
         rd_chk(ad, 8'hB1, MODE_STATUS);
         u_host_model.wr(ad, 16'h00FF);
         rd_chk(ad, 8'hB1, MODE_ARRAY);
         u_host_model.wr(ad, 16'h0050);
         rd_chk(ad, 8'h81, MODE_ARRAY);
      end
      // Every lock confirm code, confirm anywhere in the block.
      for (i = 0; i < 3; i++)
      begin
         u_host_model.wr(a, 16'h0060);
         notes.push_back(ev(3'b100, lk[i], b, lc[i]));
         u_host_model.wr(b, lc[i]);
      end
      // Both program setup codes with random word data.
      for (i = 0; i < 2; i++)
      begin
         d = 16'($urandom);
         notes.push_back(ev(3'b100, OP_PROGRAM, a, d));
         u_host_model.wr(a, i ? 16'h0010 : 16'h0040);
         u_host_model.wr(a, d);
      end
      // Protection lock word and the four user words.
      notes.push_back(ev(3'b100, OP_PROT_LOCK, 22'h000080, 16'hFFFD));
      u_host_model.wr(22'h000080, 16'h00C0);
      u_host_model.wr(22'h000080, 16'hFFFD);
      for (i = 0; i < 4; i++)
      begin
         ad = 22'h000081 + 22'(i);
         d  = 16'($urandom);
         notes.push_back(ev(3'b100, OP_PROT_PROG, ad, d));
         u_host_model.wr(ad, 16'h00C0);
         u_host_model.wr(ad, d);
      end
      u_host_model.wr(22'h000000, 16'h00FF);
      rd_chk(22'h000000, 8'h81, MODE_ARRAY);
      // Configuration value from the low address lines.
      v = 16'($urandom);
      u_host_model.wr({3'h5, 3'h0, v}, 16'h0060);
      u_host_model.wr({3'h5, 3'h7, v}, 16'h0003);
      rd_chk({3'h5, 3'h0, v}, 8'h81, MODE_ARRAY);
      chk(config_o, v);
      // Identifier, query and status modes, read at partition base plus offset.
      u_host_model.wr(22'h300000, 16'h0090);
      rd_chk(22'h300001, 8'h81, MODE_IDENT);
      u_host_model.wr(22'h300000, 16'h0098);
      rd_chk(22'h300010, 8'h81, MODE_QUERY);
      u_host_model.wr(22'h300000, 16'h0070);
      rd_chk(22'h300000, 8'h81, MODE_STATUS);
      u_host_model.wr(22'h300000, 16'h00FF);
      // Suspend and resume at arbitrary addresses.
      notes.push_back(ev(3'b010, OP_PROGRAM, 22'h300123, 16'h00B0));
      u_host_model.wr(22'h300123, 16'h00B0);
      notes.push_back(ev(3'b001, OP_PROGRAM, 22'h3004A6, 16'h00D0));
      u_host_model.wr(22'h3004A6, 16'h00D0);
      // Factory mode: the confirm launches, then writes in the captured
      // block launch, and a write to another block leaves.
      d = 16'($urandom);
      u_host_model.wr(22'h1A0010, 16'h0030);
      notes.push_back(ev(3'b100, OP_FACTORY, 22'h1A0010, 16'h00D0));
      u_host_model.wr(22'h1A0010, 16'h00D0);
      repeat (3) @(negedge clk_sys_i);
      chk(factory_program_mode_o, 1'b1);
      notes.push_back(ev(3'b100, OP_FACTORY, 22'h1A0011, d));
      u_host_model.wr(22'h1A0011, d);
      u_host_model.wr(22'h020000, 16'h00FF);
      repeat (3) @(negedge clk_sys_i);
      chk(factory_program_mode_o, 1'b0);
      // Unassigned code and a frozen write leave no trace.
      u_host_model.wr(22'h3C0000, 16'h00A5);
      ce_i = 1'b0;
      u_host_model.wr(22'h3C0000, 16'h0040);
      ce_i = 1'b1;
      u_host_model.wr(22'h3C0000, 16'h00A5);
      rd_chk(22'h3C0000, 8'h81, MODE_ARRAY);
      // Snapshot holds until the next read strobe.
      {wsm_busy_i, prog_susp_i, erase_susp_i} = 3'b111;
      repeat (3) @(negedge clk_sys_i);
      chk(status_o, 8'h81);
      rd_chk(22'h000000, 8'h44, MODE_ARRAY);
      {wsm_busy_i, prog_susp_i, erase_susp_i} = 3'b000;
      // Error inputs set sticky bits; clear-status removes them.
      {prog_err_i, erase_err_i, vpp_err_i, lock_err_i} = 4'hF;
      @(negedge clk_sys_i);
      {prog_err_i, erase_err_i, vpp_err_i, lock_err_i} = 4'h0;
      rd_chk(22'h000000, 8'hBB, MODE_ARRAY);
      u_host_model.wr(22'h123456, 16'h0050);
      rd_chk(22'h000000, 8'h81, MODE_ARRAY);
      repeat (5) @(negedge clk_sys_i);
      chk(notes.size(), 0);
      results();
   end
endmodule
`default_nettype wire
